/* design/hpd_cfg.svh */
// Register offsets, reset values and timing counts for the hub power descriptor bank
`ifndef HPD_CFG_SVH
`define HPD_CFG_SVH

`define HPD_OFF_BP_DRAW       8'h0D
`define HPD_OFF_CC_SP         8'h0E
`define HPD_OFF_CC_BP         8'h0F
`define HPD_OFF_PGOOD_DLY     8'h10
`define HPD_OFF_LANG_HI       8'h11
`define HPD_OFF_LANG_LO       8'h12
`define HPD_OFF_MSTR_LEN      8'h13

`define HPD_RST_BP_DRAW       8'h00
`define HPD_RST_CC            8'h32
`define HPD_RST_PGOOD_DLY     8'h00
`define HPD_RST_LANG_HI       8'h00
`define HPD_RST_LANG_LO       8'h00
`define HPD_RST_MSTR_LEN      8'h00

`define HPD_STR_MAX_CHARS     8'h1F
`define HPD_UNIT_MA           2
`define HPD_PGOOD_UNIT_NS     2000000
`define HPD_CLK_PERIOD_NS     8

`endif

/* design/hpd_pkg.sv */
// Types shared by the hub power descriptor bank
package hpd_pkg;

   // Power figures handed to the descriptor logic
   typedef struct packed {
      logic [15:0] upstream_draw_ma;
      logic [15:0] controller_ma;
   } hpd_power_t;

   // String geometry handed to the string logic
   typedef struct packed {
      logic [4:0]  char_count;
      logic [5:0]  byte_count;
   } hpd_string_t;

endpackage : hpd_pkg

/* design/hpd_bank.sv */
// Hub power descriptor configuration bank
//
// Function
// - Bus-powered upstream draw is an unsigned count of 2 mA units.
// - Self-powered controller current is counted in 2 mA units, excluding peripherals.
// - Self-powered controller current resets to 50, meaning 100 mA.
// - Bus-powered controller current is counted in 2 mA units, excluding peripherals.
// - Bus-powered controller current resets to 50, meaning 100 mA.
// - Power-good delay counts 2 ms intervals from port power-on start.
// - Language identifier is high byte register above low byte register.
// - Maker string length is at most 31 characters; longer is not honoured.
// - Each string character is two bytes, low byte first, bytes twice chars.
`timescale 1ns/10ps
`include "hpd_cfg.svh"

module hpd_bank #(
   parameter int PGOOD_UNIT_CYC = `HPD_PGOOD_UNIT_NS / `HPD_CLK_PERIOD_NS
) (
   input  wire logic                core_clk_in,
   input  wire logic                resetn_in,
   input  wire logic                clk_en_in,
   input  wire logic                cfg_wr_in,
   input  wire logic [7:0]          cfg_addr_in,
   input  wire logic [7:0]          cfg_wdata_in,
   output logic      [7:0]          cfg_rdata_out,
   input  wire logic                self_powered_in,
   input  wire logic                port_pwr_start_in,
   output logic                     port_pwr_good_out,
   output hpd_pkg::hpd_power_t      power_out,
   output logic      [15:0]         lang_id_out,
   output hpd_pkg::hpd_string_t     maker_string_out
);

   // =====================================================================
   // Parameter check
   // =====================================================================
   // A zero-cycle unit would leave the interval counter no edge to count on
   if (PGOOD_UNIT_CYC < 1) begin : g_bad_unit
      $error("PGOOD_UNIT_CYC must be at least one cycle");
   end

   // 2 mA unit count to milliamps
   // A shift, not a multiply, since the unit is a power of two
   function automatic logic [15:0] to_ma(input logic [7:0] units);
      to_ma = 16'({units, 1'b0});
   endfunction : to_ma

   // =====================================================================
   // Register bank
   // =====================================================================
   logic [7:0] bp_draw_r,   bp_draw_nxt;
   logic [7:0] cc_sp_r,     cc_sp_nxt;
   logic [7:0] cc_bp_r,     cc_bp_nxt;
   logic [7:0] pgood_dly_r, pgood_dly_nxt;
   logic [7:0] lang_hi_r,   lang_hi_nxt;
   logic [7:0] lang_lo_r,   lang_lo_nxt;
   logic [7:0] mstr_len_r,  mstr_len_nxt;
   logic [7:0] rdata_r,     rdata_nxt;

   // Write decode and registered read data; read data shows the value after
   // any same-cycle write so a read-back never returns a stale byte
   always_comb begin
      bp_draw_nxt   = bp_draw_r;
      cc_sp_nxt     = cc_sp_r;
      cc_bp_nxt     = cc_bp_r;
      pgood_dly_nxt = pgood_dly_r;
      lang_hi_nxt   = lang_hi_r;
      lang_lo_nxt   = lang_lo_r;
      mstr_len_nxt  = mstr_len_r;
      if (cfg_wr_in) begin
         unique case (cfg_addr_in)
            `HPD_OFF_BP_DRAW:   bp_draw_nxt   = cfg_wdata_in;
            `HPD_OFF_CC_SP:     cc_sp_nxt     = cfg_wdata_in;
            `HPD_OFF_CC_BP:     cc_bp_nxt     = cfg_wdata_in;
            `HPD_OFF_PGOOD_DLY: pgood_dly_nxt = cfg_wdata_in;
            `HPD_OFF_LANG_HI:   lang_hi_nxt   = cfg_wdata_in;
            `HPD_OFF_LANG_LO:   lang_lo_nxt   = cfg_wdata_in;
            `HPD_OFF_MSTR_LEN:  mstr_len_nxt  = cfg_wdata_in;
            default: ;
         endcase
      end
      // Unmapped offsets read as zero
      unique case (cfg_addr_in)
         `HPD_OFF_BP_DRAW:   rdata_nxt = bp_draw_nxt;
         `HPD_OFF_CC_SP:     rdata_nxt = cc_sp_nxt;
         `HPD_OFF_CC_BP:     rdata_nxt = cc_bp_nxt;
         `HPD_OFF_PGOOD_DLY: rdata_nxt = pgood_dly_nxt;
         `HPD_OFF_LANG_HI:   rdata_nxt = lang_hi_nxt;
         `HPD_OFF_LANG_LO:   rdata_nxt = lang_lo_nxt;
         `HPD_OFF_MSTR_LEN:  rdata_nxt = mstr_len_nxt;
         default:            rdata_nxt = 8'h00;
      endcase
   end

   // Register storage with power-on defaults; frozen while the enable is low
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bp_draw_r   <= `HPD_RST_BP_DRAW;
         cc_sp_r     <= `HPD_RST_CC;
         cc_bp_r     <= `HPD_RST_CC;
         pgood_dly_r <= `HPD_RST_PGOOD_DLY;
         lang_hi_r   <= `HPD_RST_LANG_HI;
         lang_lo_r   <= `HPD_RST_LANG_LO;
         mstr_len_r  <= `HPD_RST_MSTR_LEN;
         rdata_r     <= 8'h00;
      end else if (clk_en_in) begin
         bp_draw_r   <= bp_draw_nxt;
         cc_sp_r     <= cc_sp_nxt;
         cc_bp_r     <= cc_bp_nxt;
         pgood_dly_r <= pgood_dly_nxt;
         lang_hi_r   <= lang_hi_nxt;
         lang_lo_r   <= lang_lo_nxt;
         mstr_len_r  <= mstr_len_nxt;
         rdata_r     <= rdata_nxt;
      end
   end

   assign cfg_rdata_out = rdata_r;

   // =====================================================================
   // Descriptor outputs
   // =====================================================================
   hpd_pkg::hpd_power_t  power_r,  power_nxt;
   hpd_pkg::hpd_string_t mstr_r,   mstr_nxt;
   logic [15:0]          lang_r,   lang_nxt;
   logic [4:0]           chars;

   // Mode selects the pair; bus-powered draw already folds in any
   // embedded peripheral, so no extra term is added here
   // Self-powered upstream draw is held elsewhere, so zero stands in here.
   // Values above 100 mA pass through as written; keeping them legal is
   // the configurer's job
   always_comb begin
      if (self_powered_in) begin
         power_nxt.upstream_draw_ma = 16'h0000;
         power_nxt.controller_ma    = to_ma(cc_sp_r);
      end else begin
         power_nxt.upstream_draw_ma = to_ma(bp_draw_r);
         power_nxt.controller_ma    = to_ma(cc_bp_r);
      end
      lang_nxt = {lang_hi_r, lang_lo_r};
      // Overlong lengths are clamped so the string logic never runs past 31
      chars = (mstr_len_r > `HPD_STR_MAX_CHARS) ? 5'h1F : mstr_len_r[4:0];
      mstr_nxt.char_count = chars;
      mstr_nxt.byte_count = {chars, 1'b0};
   end

   // Registered so the descriptor logic never sees a half-updated pair
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         power_r <= '0;
         lang_r  <= 16'h0000;
         mstr_r  <= '0;
      end else if (clk_en_in) begin
         power_r <= power_nxt;
         lang_r  <= lang_nxt;
         mstr_r  <= mstr_nxt;
      end
   end

   assign power_out        = power_r;
   assign lang_id_out      = lang_r;
   assign maker_string_out = mstr_r;

   // =====================================================================
   // Port power-good timer
   // =====================================================================
   logic [31:0] unit_cnt_r,  unit_cnt_nxt;
   logic [7:0]  ivl_cnt_r,   ivl_cnt_nxt;
   logic        busy_r,      busy_nxt;
   logic        good_r,      good_nxt;

   // Counts delay intervals of 2 ms; a zero delay gives good next cycle.
   // A fresh start restarts the wait and drops good, unless the delay is zero.
   // Limitation: rewriting the delay mid-wait retargets the compare, and a
   // delay cut below the elapsed count waits out the full 8-bit wrap
   always_comb begin
      unit_cnt_nxt = unit_cnt_r;
      ivl_cnt_nxt  = ivl_cnt_r;
      busy_nxt     = busy_r;
      good_nxt     = good_r;
      if (port_pwr_start_in) begin
         unit_cnt_nxt = 32'h00000000;
         ivl_cnt_nxt  = 8'h00;
         busy_nxt     = (pgood_dly_r != 8'h00);
         good_nxt     = (pgood_dly_r == 8'h00);
      end else if (busy_r) begin
         if (unit_cnt_r == 32'(PGOOD_UNIT_CYC - 1)) begin
            unit_cnt_nxt = 32'h00000000;
            if (ivl_cnt_r == pgood_dly_r - 8'h01) begin
               busy_nxt = 1'b0;
               good_nxt = 1'b1;
            end else begin
               ivl_cnt_nxt = ivl_cnt_r + 8'h01;
            end
         end else begin
            unit_cnt_nxt = unit_cnt_r + 32'h00000001;
         end
      end
   end

   // Timer state freezes with the clock enable like the bank
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         unit_cnt_r <= 32'h00000000;
         ivl_cnt_r  <= 8'h00;
         busy_r     <= 1'b0;
         good_r     <= 1'b0;
      end else if (clk_en_in) begin
         unit_cnt_r <= unit_cnt_nxt;
         ivl_cnt_r  <= ivl_cnt_nxt;
         busy_r     <= busy_nxt;
         good_r     <= good_nxt;
      end
   end

   assign port_pwr_good_out = good_r;

endmodule : hpd_bank

/* testbench/hpd_bank_monitor.sv */
// Port checker for the hub power descriptor bank
`timescale 1ns/10ps
module hpd_bank_monitor #(parameter int PGOOD_UNIT_CYC = 4) (
   input wire logic                 core_clk_in,
   input wire logic                 resetn_in,
   input wire logic                 clk_en_in,
   input wire logic                 cfg_wr_in,
   input wire logic [7:0]           cfg_addr_in,
   input wire logic [7:0]           cfg_wdata_in,
   input wire logic [7:0]           cfg_rdata_out,
   input wire logic                 self_powered_in,
   input wire logic                 port_pwr_start_in,
   input wire logic                 port_pwr_good_out,
   input wire hpd_pkg::hpd_power_t  power_out,
   input wire logic [15:0]          lang_id_out,
   input wire hpd_pkg::hpd_string_t maker_string_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);
   // Enabled write plus one enabled edge with the mode held, so derived outputs show it next
   sequence s_wr(a, m);
      clk_en_in && cfg_wr_in && cfg_addr_in == a && self_powered_in == m ##1 clk_en_in && self_powered_in == m;
   endsequence
   property p_lh; s_wr(8'h11, self_powered_in) |=> lang_id_out[15:8] == $past(cfg_wdata_in, 2); endproperty
   a_lh: assert property (p_lh) else $error("lang high");
   property p_ll; s_wr(8'h12, self_powered_in) |=> lang_id_out[7:0] == $past(cfg_wdata_in, 2); endproperty
   a_ll: assert property (p_ll) else $error("lang low");
   property p_dr; s_wr(8'h0D, 1'b0) |=> power_out.upstream_draw_ma == 2 * $past(cfg_wdata_in, 2); endproperty
   a_dr: assert property (p_dr) else $error("draw");
   property p_cs; s_wr(8'h0E, 1'b1) |=> power_out.controller_ma == 2 * $past(cfg_wdata_in, 2); endproperty
   a_cs: assert property (p_cs) else $error("ctrl sp");
   property p_cb; s_wr(8'h0F, 1'b0) |=> power_out.controller_ma == 2 * $past(cfg_wdata_in, 2); endproperty
   a_cb: assert property (p_cb) else $error("ctrl bp");
   property p_sd; clk_en_in && self_powered_in |=> power_out.upstream_draw_ma == 16'h0000; endproperty
   a_sd: assert property (p_sd) else $error("sp draw");
   property p_by; maker_string_out.byte_count == {maker_string_out.char_count, 1'b0}; endproperty
   a_by: assert property (p_by) else $error("bytes");
   property p_pg; clk_en_in && port_pwr_good_out && !port_pwr_start_in |=> port_pwr_good_out; endproperty
   a_pg: assert property (p_pg) else $error("good hold");
   // Shadow of the delay register and edges since the last start
   logic [7:0]  dly_shadow_r;
   logic [31:0] wait_cnt_r;
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dly_shadow_r <= 8'h00;
         wait_cnt_r   <= 32'h00000000;
      end else if (clk_en_in) begin
         if (cfg_wr_in && cfg_addr_in == 8'h10) begin
            dly_shadow_r <= cfg_wdata_in;
         end
         if (port_pwr_start_in) begin
            wait_cnt_r <= 32'h00000000;
         end else if (!port_pwr_good_out) begin
            wait_cnt_r <= wait_cnt_r + 32'h00000001;
         end
      end
   end
   property p_pt; $rose(port_pwr_good_out) |-> wait_cnt_r == 32'(dly_shadow_r) * 32'(PGOOD_UNIT_CYC); endproperty
   a_pt: assert property (p_pt) else $error("good timing");
endmodule : hpd_bank_monitor

/* testbench/hpd_host_model.sv */
// Host model that powers a port and times power-good
`timescale 1ns/10ps
module hpd_host_model (
   input  wire logic core_clk_in,
   input  wire logic port_pwr_good_out,
   output logic      port_pwr_start_in = 1'b0
);
   // One-cycle start from falling edges; wait is capped so a dead port cannot hang
   task automatic power_on(output int n);
      @(negedge core_clk_in) port_pwr_start_in = 1'b1;
      @(negedge core_clk_in) port_pwr_start_in = 1'b0;
      for (n = 0; port_pwr_good_out !== 1'b1 && n < 99; n++) @(negedge core_clk_in);
   endtask : power_on
endmodule : hpd_host_model

/* testbench/hpd_bank_tb_top.sv */
// Self-checking bench for the hub power descriptor bank
`timescale 1ns/10ps
module hpd_bank_tb_top;
   localparam int PG = 4;
   logic                 core_clk_in = 1'b0, resetn_in = 1'b0, clk_en_in = 1'b1, cfg_wr_in = 1'b0;
   logic                 self_powered_in = 1'b0, port_pwr_start_in, port_pwr_good_out;
   logic [7:0]           cfg_addr_in = 8'h00, cfg_wdata_in = 8'h00, cfg_rdata_out;
   logic [15:0]          lang_id_out;
   hpd_pkg::hpd_power_t  power_out;
   hpd_pkg::hpd_string_t maker_string_out;
   int                   fail_count = 0, n_checks = 0, n;
   // Short power-good unit keeps the run brief; the host drives the start pulse
   hpd_bank #(.PGOOD_UNIT_CYC(PG)) dut_u (
      .core_clk_in       (core_clk_in),
      .resetn_in         (resetn_in),
      .clk_en_in         (clk_en_in),
      .cfg_wr_in         (cfg_wr_in),
      .cfg_addr_in       (cfg_addr_in),
      .cfg_wdata_in      (cfg_wdata_in),
      .cfg_rdata_out     (cfg_rdata_out),
      .self_powered_in   (self_powered_in),
      .port_pwr_start_in (port_pwr_start_in),
      .port_pwr_good_out (port_pwr_good_out),
      .power_out         (power_out),
      .lang_id_out       (lang_id_out),
      .maker_string_out  (maker_string_out)
   );
   hpd_host_model host_u (
      .core_clk_in       (core_clk_in),
      .port_pwr_good_out (port_pwr_good_out),
      .port_pwr_start_in (port_pwr_start_in)
   );
   initial forever #4 core_clk_in = ~core_clk_in;
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      fail_count += int'(seen !== exp);
      if (seen !== exp) $display("mismatch %s expected %h seen %h", what, exp, seen);
   endtask : chk
   // Strobe for one edge, then two edges so derived outputs settle
   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(negedge core_clk_in) {cfg_wr_in, cfg_addr_in, cfg_wdata_in} = {1'b1, a, d};
      @(negedge core_clk_in) cfg_wr_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
   endtask : wr_reg
   task automatic rd_chk(logic [7:0] a, logic [7:0] e);
      @(negedge core_clk_in) cfg_addr_in = a;
      @(negedge core_clk_in) chk("rdata", 32'(cfg_rdata_out), 32'(e));
   endtask : rd_chk
   task automatic close_out(int hung);
      fail_count += hung;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out
   task automatic t_regs();
      rd_chk(8'h0E, 8'h32);
      rd_chk(8'h0F, 8'h32);
      wr_reg(8'h14, 8'h5A);
      rd_chk(8'h14, 8'h00);
      wr_reg(8'h0D, 8'hFF);
      wr_reg(8'h0F, 8'hC8);
      rd_chk(8'h0D, 8'hFF);
      chk("bp power", power_out, 32'h01FE_0190);
      self_powered_in = 1'b1;
      wr_reg(8'h0E, 8'h10);
      chk("sp power", power_out, 32'h0000_0020);
      $display("test regs done");
   endtask : t_regs
   task automatic t_str();
      logic [7:0]  len [4] = '{8'h05, 8'h1F, 8'h20, 8'hFF};
      logic [10:0] ex [4] = '{11'h14A, 11'h7FE, 11'h7FE, 11'h7FE};
      wr_reg(8'h11, 8'h04);
      wr_reg(8'h12, 8'h09);
      chk("lang", 32'(lang_id_out), 32'h0000_0409);
      foreach (len[i]) begin
         wr_reg(8'h13, len[i]);
         chk("string", 32'(maker_string_out), 32'(ex[i]));
      end
      // Enable low: a strobed write must not land
      clk_en_in = 1'b0;
      wr_reg(8'h13, 8'h05);
      chk("string frozen", 32'(maker_string_out), 32'h0000_07FE);
      clk_en_in = 1'b1;
      rd_chk(8'h13, 8'hFF);
      $display("test string done");
   endtask : t_str
   task automatic t_pgood();
      wr_reg(8'h10, 8'h03);
      host_u.power_on(n);
      chk("good wait", 32'(n), 32'(3 * PG));
      rd_chk(8'h10, 8'h03);
      $display("test power-good done");
   endtask : t_pgood
   // Mid-run reset: written values and power-good return to defaults
   task automatic t_rst();
      @(negedge core_clk_in) resetn_in = 1'b0;
      repeat (2) @(negedge core_clk_in);
      resetn_in = 1'b1;
      chk("good rst", 32'(port_pwr_good_out), 32'h0000_0000);
      rd_chk(8'h0E, 8'h32);
      rd_chk(8'h0F, 8'h32);
      chk("sp power rst", power_out, 32'h0000_0064);
      $display("test reset done");
   endtask : t_rst
   // Reset over three edges, then the scenarios in turn
   initial begin
      repeat (3) @(negedge core_clk_in);
      resetn_in = 1'b1;
      t_regs();
      t_str();
      t_pgood();
      t_rst();
      close_out(0);
   end
   // Hang guard far beyond the 84 or so cycles the scenarios need
   initial #100000 close_out(1);
endmodule : hpd_bank_tb_top
bind hpd_bank hpd_bank_monitor #(.PGOOD_UNIT_CYC(PGOOD_UNIT_CYC)) mon_u (
   .core_clk_in       (core_clk_in),
   .resetn_in         (resetn_in),
   .clk_en_in         (clk_en_in),
   .cfg_wr_in         (cfg_wr_in),
   .cfg_addr_in       (cfg_addr_in),
   .cfg_wdata_in      (cfg_wdata_in),
   .cfg_rdata_out     (cfg_rdata_out),
   .self_powered_in   (self_powered_in),
   .port_pwr_start_in (port_pwr_start_in),
   .port_pwr_good_out (port_pwr_good_out),
   .power_out         (power_out),
   .lang_id_out       (lang_id_out),
   .maker_string_out  (maker_string_out)
);
